// ===== hdl/tpc_defines.svh
// Register map, field positions, codes and reset values of the timer/PWM counter block
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_CNTL 8'h04
`define TPC_OFF_CNTH 8'h08
`define TPC_OFF_MODL 8'h0c
`define TPC_OFF_MODH 8'h10
`define TPC_OFF_CHBASE 8'h20
`define TPC_CH_STRIDE 8'h10
`define TPC_CH_SC 8'h00
`define TPC_CH_VH 8'h04
`define TPC_CH_VL 8'h08

`define TPC_SC_FLAG 7
`define TPC_SC_IE 6
`define TPC_SC_CENTER_PWM_MODE 5
`define TPC_SC_CLKHI 4
`define TPC_SC_CLKLO 3
`define TPC_SC_PSHI 2
`define TPC_SC_PSLO 0
`define TPC_CH_FLAG 7
`define TPC_CH_IE 6
`define TPC_CH_MSB 5
`define TPC_CH_MSA 4
`define TPC_CH_ELSB 3
`define TPC_CH_ELSA 2

`define TPC_RST_VAL 16'h0000
`define TPC_CNT_MAX 16'hffff
`define TPC_CLK_NONE 2'h0
`define TPC_CLK_BUS 2'h1
`define TPC_CLK_FIXED 2'h2
`define TPC_CLK_EXT 2'h3
`define TPC_ELS_OFF 2'h0

`endif

// ===== hdl/tpc_pkg.sv
// Types shared by the timer/PWM counter block
package tpc_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} tpc_bus_type;
  typedef struct packed {
    logic out;
    logic oeN;
  } tpc_pin_type;
  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic elsb;
    logic elsa;
    logic [15:0] val;
    logic [15:0] buf16;
    logic wrHi;
    logic wrLo;
    logic pend;
    logic rdLat;
    logic rdFromHi;
    logic [15:0] rdBuf;
    logic pinOut;
    logic [2:0] sync;
  } tpc_chan_type;
endpackage

// ===== hdl/tpc_timer.sv
// Timer/PWM counter with channels, AHB-Lite register slave
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_timer #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clock sources and debug
  input wire logic debugHalt,
  input wire logic pllEngaged,
  input wire logic fixedClkIn,
  input wire logic extClkIn,
  // Channel pins and interrupt
  input wire logic [NUM_CH-1:0] chIn,
  output tpc_pkg::tpc_pin_type [NUM_CH-1:0] chPin,
  output logic overflowIrq
);
  import tpc_pkg::*;

  initial begin
    if (NUM_CH < 1 || NUM_CH > 8) begin
      $error("NUM_CH must be 1 to 8");
    end
  end

  typedef struct packed {
    tpc_bus_type phase;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic ovf;
    logic ie;
    logic center_pwm_mode;
    logic [1:0] clk;
    logic [2:0] ps;
    logic [6:0] psCnt;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic dirDown;
    logic [2:0] extS;
    logic [2:0] fixS;
    tpc_chan_type [NUM_CH-1:0] ch;
  } tpc_state_type;

  tpc_state_type s_q;
  tpc_state_type s_d;

  // Counter step, shared by the state update and the checks
  logic srcTick;
  logic tick;
  logic [15:0] term;
  logic [6:0] psLim;
  logic [15:0] cntNext;
  logic movingUp;
  logic wrapNow;
  logic pwmStep;

  // Synchronised edges: external clock always, fixed clock only with PLL
  assign term = (s_q.modv == `TPC_RST_VAL) ? `TPC_CNT_MAX : s_q.modv;
  assign psLim = 7'((8'h1 << s_q.ps) - 8'h1);
  always_comb begin
    case (s_q.clk)
      `TPC_CLK_BUS: srcTick = 1'b1;
      `TPC_CLK_FIXED: srcTick = pllEngaged ? (s_q.fixS[1] & ~s_q.fixS[2]) : 1'b1;
      `TPC_CLK_EXT: srcTick = s_q.extS[1] & ~s_q.extS[2];
      default: srcTick = 1'b0;
    endcase
  end
  // Counter holds still while halted
  assign tick = srcTick && !debugHalt && s_q.psCnt == psLim;

  always_comb begin
    cntNext = s_q.cnt;
    movingUp = 1'b1;
    wrapNow = 1'b0;
    if (!s_q.center_pwm_mode) begin
      if (s_q.cnt == term) begin
        cntNext = `TPC_RST_VAL;
        wrapNow = 1'b1;
      end else begin
        cntNext = s_q.cnt + 16'h1;
      end
    end else if (!s_q.dirDown) begin
      if (s_q.cnt >= term) begin
        cntNext = s_q.cnt - 16'h1;
        movingUp = 1'b0;
        wrapNow = 1'b1;
      end else begin
        cntNext = s_q.cnt + 16'h1;
      end
    end else begin
      movingUp = (s_q.cnt == `TPC_RST_VAL);
      cntNext = movingUp ? s_q.cnt + 16'h1 : s_q.cnt - 16'h1;
    end
  end
  assign pwmStep = tick && movingUp && s_q.cnt == term - 16'h1;

  always_comb begin
    logic acc;
    logic [7:0] wd;
    logic [7:0] rd;
    logic ic;
    logic oc;
    logic ep;
    logic off;
    logic rise;
    logic fall;
    logic match;
    logic zero;
    logic isHi;
    logic [7:0] base;
    acc = 1'b0;
    wd = hwdata[7:0];
    rd = 8'h00;
    ic = 1'b0;
    oc = 1'b0;
    ep = 1'b0;
    off = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    match = 1'b0;
    zero = 1'b0;
    isHi = 1'b0;
    base = 8'h00;
    s_d = s_q;
    s_d.extS = {s_q.extS[1:0], extClkIn};
    s_d.fixS = {s_q.fixS[1:0], fixedClkIn};

    // Bus: reads take one wait state so a preceding write is already visible
    acc = hready && hsel && htrans[1];
    if (s_q.phase == BUS_READ_WAIT) begin
      s_d.phase = BUS_READ_DONE;
    end else if (hready) begin
      s_d.phase = acc ? (hwrite ? BUS_WRITE : BUS_READ_WAIT) : BUS_IDLE;
      s_d.addr = haddr[7:0];
    end

    if (s_q.phase == BUS_WRITE) begin
      case (s_q.addr)
        `TPC_OFF_CTRL: begin
          if (!wd[`TPC_SC_FLAG]) begin
            s_d.ovf = 1'b0;
          end
          s_d.ie = wd[`TPC_SC_IE];
          s_d.center_pwm_mode = wd[`TPC_SC_CENTER_PWM_MODE];
          s_d.clk = wd[`TPC_SC_CLKHI:`TPC_SC_CLKLO];
          s_d.ps = wd[`TPC_SC_PSHI:`TPC_SC_PSLO];
        end
        `TPC_OFF_MODL: s_d.modv[7:0] = wd;
        `TPC_OFF_MODH: s_d.modv[15:8] = wd;
        default: ;
      endcase
    end
    if (s_q.phase == BUS_READ_WAIT) begin
      case (s_q.addr)
        `TPC_OFF_CTRL: rd = {s_q.ovf, s_q.ie, s_q.center_pwm_mode, s_q.clk, s_q.ps};
        `TPC_OFF_CNTL: rd = s_q.cnt[7:0];
        `TPC_OFF_CNTH: rd = s_q.cnt[15:8];
        `TPC_OFF_MODL: rd = s_q.modv[7:0];
        `TPC_OFF_MODH: rd = s_q.modv[15:8];
        default: rd = 8'h00;
      endcase
    end

    // Prescaler and counter; a stopped source leaves every value alone
    if (srcTick && !debugHalt) begin
      s_d.psCnt = tick ? 7'h00 : s_q.psCnt + 7'h1;
    end
    if (tick) begin
      s_d.cnt = cntNext;
      s_d.dirDown = s_q.center_pwm_mode && !movingUp;
      if (wrapNow) begin
        s_d.ovf = 1'b1;
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin
      base = 8'(`TPC_OFF_CHBASE + i * `TPC_CH_STRIDE);
      ic = !s_q.center_pwm_mode && !s_q.ch[i].msb && !s_q.ch[i].msa;
      oc = !s_q.center_pwm_mode && !s_q.ch[i].msb && s_q.ch[i].msa;
      ep = !s_q.center_pwm_mode && s_q.ch[i].msb;
      off = {s_q.ch[i].elsb, s_q.ch[i].elsa} == `TPC_ELS_OFF;
      s_d.ch[i].sync = {s_q.ch[i].sync[1:0], chIn[i]};

      if (s_q.phase == BUS_WRITE && s_q.addr == base + `TPC_CH_SC) begin
        if (!wd[`TPC_CH_FLAG]) begin
          s_d.ch[i].flag = 1'b0;
        end
        s_d.ch[i].ie = wd[`TPC_CH_IE];
        s_d.ch[i].msb = wd[`TPC_CH_MSB];
        s_d.ch[i].msa = wd[`TPC_CH_MSA];
        s_d.ch[i].elsb = wd[`TPC_CH_ELSB];
        s_d.ch[i].elsa = wd[`TPC_CH_ELSA];
        s_d.ch[i].rdLat = 1'b0;
        s_d.ch[i].wrHi = 1'b0;
        s_d.ch[i].wrLo = 1'b0;
      end
      isHi = s_q.addr == base + `TPC_CH_VH;
      if (s_q.phase == BUS_WRITE && !ic && (isHi || s_q.addr == base + `TPC_CH_VL)) begin
        if (debugHalt) begin
          if (isHi) begin
            s_d.ch[i].val[15:8] = wd;
          end else begin
            s_d.ch[i].val[7:0] = wd;
          end
        end else begin
          if (isHi) begin
            s_d.ch[i].buf16[15:8] = wd;
            s_d.ch[i].wrHi = 1'b1;
          end else begin
            s_d.ch[i].buf16[7:0] = wd;
            s_d.ch[i].wrLo = 1'b1;
          end
          if ((isHi ? s_q.ch[i].wrLo : s_q.ch[i].wrHi)) begin
            s_d.ch[i].wrHi = 1'b0;
            s_d.ch[i].wrLo = 1'b0;
            if (s_q.clk == `TPC_CLK_NONE) begin
              s_d.ch[i].val = s_d.ch[i].buf16;
              s_d.ch[i].pend = 1'b0;
            end else begin
              s_d.ch[i].pend = 1'b1;
            end
          end
        end
      end

      if (s_q.phase == BUS_READ_WAIT) begin
        if (s_q.addr == base + `TPC_CH_SC) begin
          rd = {s_q.ch[i].flag, s_q.ch[i].ie, s_q.ch[i].msb, s_q.ch[i].msa,
                s_q.ch[i].elsb, s_q.ch[i].elsa, 2'h0};
        end else if (isHi || s_q.addr == base + `TPC_CH_VL) begin
          rd = isHi ? s_q.ch[i].val[15:8] : s_q.ch[i].val[7:0];
          if (ic && !debugHalt) begin
            if (s_q.ch[i].rdLat) begin
              rd = isHi ? s_q.ch[i].rdBuf[15:8] : s_q.ch[i].rdBuf[7:0];
              if (s_q.ch[i].rdFromHi != isHi) begin
                s_d.ch[i].rdLat = 1'b0;
              end
            end else begin
              s_d.ch[i].rdLat = 1'b1;
              s_d.ch[i].rdFromHi = isHi;
              s_d.ch[i].rdBuf = s_q.ch[i].val;
            end
          end
        end
      end

      // Pending buffered value reaches the channel register
      if (s_q.ch[i].pend && ((oc && tick) || ((ep || s_q.center_pwm_mode) && pwmStep))) begin
        s_d.ch[i].val = s_q.ch[i].buf16;
        s_d.ch[i].pend = 1'b0;
      end

      rise = s_q.ch[i].sync[1] & ~s_q.ch[i].sync[2];
      fall = ~s_q.ch[i].sync[1] & s_q.ch[i].sync[2];
      match = tick && cntNext == s_q.ch[i].val;
      zero = s_q.ch[i].val == `TPC_RST_VAL;
      if (ic && !off && ((s_q.ch[i].elsa && rise) || (s_q.ch[i].elsb && fall))) begin
        s_d.ch[i].val = s_q.cnt;
        s_d.ch[i].flag = 1'b1;
      end else if (oc && match) begin
        s_d.ch[i].flag = 1'b1;
        case ({s_q.ch[i].elsb, s_q.ch[i].elsa})
          2'h1: s_d.ch[i].pinOut = ~s_q.ch[i].pinOut;
          2'h2: s_d.ch[i].pinOut = 1'b0;
          2'h3: s_d.ch[i].pinOut = 1'b1;
          default: ;
        endcase
      end else if (ep) begin
        if (tick && wrapNow) begin
          s_d.ch[i].pinOut = ~s_q.ch[i].elsa;
        end
        if (match) begin
          s_d.ch[i].pinOut = s_q.ch[i].elsa;
          s_d.ch[i].flag = s_q.ch[i].flag | !zero;
        end
      end else if (s_q.center_pwm_mode) begin
        zero = zero || s_q.ch[i].val[15];
        if (zero) begin
          s_d.ch[i].pinOut = s_q.ch[i].elsa;
        end else if (match) begin
          s_d.ch[i].pinOut = movingUp ? s_q.ch[i].elsa : ~s_q.ch[i].elsa;
          s_d.ch[i].flag = 1'b1;
        end
      end
    end
    s_d.rdata = rd;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chPin[i].out = s_q.ch[i].pinOut;
      // Capture pins and code 00 leave the pin undriven
      chPin[i].oeN = ({s_q.ch[i].elsb, s_q.ch[i].elsa} == `TPC_ELS_OFF)
        || (!s_q.center_pwm_mode && !s_q.ch[i].msb && !s_q.ch[i].msa);
    end
  end

  assign overflowIrq = s_q.ovf && s_q.ie;
  assign hreadyout = s_q.phase != BUS_READ_WAIT;
  assign hresp = 1'b0;
  assign hrdata = {24'h0, s_q.rdata};

  // Checks; the channel checks look at channel 0 only
  logic ic0;
  logic cap0;
  assign ic0 = !s_q.center_pwm_mode && !s_q.ch[0].msb && !s_q.ch[0].msa;
  assign cap0 = ic0 && (s_q.ch[0].sync[1] != s_q.ch[0].sync[2]);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_irq_follows_flag: assert property ($rose(s_q.ovf) && s_q.ie |-> overflowIrq)
    else $error("overflow interrupt missing");
  a_pin_release: assert property ({s_q.ch[0].elsb, s_q.ch[0].elsa} == 2'h0 |-> chPin[0].oeN)
    else $error("released pin still driven");
  a_clk_reset: assert property ($rose(rst_n) |-> s_q.clk == 2'h0 && s_q.ch[0].val == 16'h0)
    else $error("clock field not cleared by reset");
  a_stop_holds: assert property (s_q.clk == 2'h0 |=> $stable(s_q.cnt))
    else $error("stopped counter moved");
  a_up_wrap: assert property (tick && !s_q.center_pwm_mode && s_q.cnt == term |=> s_q.cnt == 16'h0 && s_q.ovf)
    else $error("up counter wrap wrong");
  a_center_turn: assert property (tick && s_q.center_pwm_mode && !s_q.dirDown && s_q.cnt == term
    |=> s_q.dirDown && s_q.ovf && s_q.cnt == $past(term) - 16'h1)
    else $error("center reversal wrong");
  a_ic_no_write: assert property (s_q.phase == BUS_WRITE && ic0 && !cap0
    && s_q.addr == `TPC_OFF_CHBASE + `TPC_CH_VH |=> $stable(s_q.ch[0].val))
    else $error("capture value written");
  a_rd_latch: assert property (s_q.phase == BUS_READ_WAIT && ic0 && !debugHalt
    && !s_q.ch[0].rdLat && s_q.addr == `TPC_OFF_CHBASE + `TPC_CH_VL |=> s_q.ch[0].rdLat)
    else $error("read latch not set");
  a_halt_freeze: assert property (debugHalt && s_q.phase != BUS_WRITE |=> $stable(s_q.ch[0].rdLat))
    else $error("latch moved in halt");
  a_sc_unlatch: assert property (s_q.phase == BUS_WRITE && s_q.addr == `TPC_OFF_CHBASE
    |=> !s_q.ch[0].rdLat && !s_q.ch[0].wrHi && !s_q.ch[0].wrLo)
    else $error("control write kept latches");
  a_read_wait: assert property (s_q.phase == BUS_READ_WAIT |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_capture: cover property (cap0 ##1 s_q.ch[0].flag);
  c_edge_pwm_mode_cycle: cover property (!s_q.center_pwm_mode && s_q.ch[0].msb && tick && wrapNow);
  c_center_turn: cover property (s_q.center_pwm_mode && tick && wrapNow);
  c_pend_load: cover property (s_q.ch[0].pend ##1 !s_q.ch[0].pend);
endmodule

// ===== test/tb.sv
// Self-checking testbench for the timer/PWM counter block
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tb;
  import tpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic debugHalt = 1'b0;
  logic [1:0] chIn = 2'h0;
  tpc_pin_type [1:0] chPin;
  logic overflowIrq;
  int mismatches = 0;
  int total_checks = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #5 core_clk = ~core_clk;

  tpc_timer #(.NUM_CH(2)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .debugHalt(debugHalt),
    .pllEngaged(1'b0), .fixedClkIn(1'b0), .extClkIn(1'b0), .chIn(chIn),
    .chPin(chPin), .overflowIrq(overflowIrq)
  );

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready is looked at on the falling edge, it only moves after a rising one
  task automatic waitRdy();
    int n;
    n = 0;
    @(negedge core_clk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitRdy();
    r = hrdata[7:0];
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    bus(a, 1'b0, 8'h00, r);
  endtask

  function automatic logic [7:0] chAddr(input int ch, input logic [7:0] off);
    return `TPC_OFF_CHBASE + 8'(ch * 16) + off;
  endfunction

  // High cycles per period for edge or center PWM
  function automatic int pwmHigh(input int v, input int m, input bit cp, input bit lt);
    int per;
    int hi;
    per = cp ? 2 * m : m + 1;
    hi = cp ? 2 * v : v;
    return lt ? per - hi : hi;
  endfunction

  task automatic cntHigh(input int ch, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge core_clk);
      h += int'(chPin[ch].out);
    end
    @(posedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [7:0] r;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [1:0] e;
    logic [15:0] v;
    int m;
    int h;
    int ch;
    void'($urandom(32'h35acbf68));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`TPC_OFF_CTRL, r);
    chk(r, 0);
    for (int c = 0; c < 2; c++) begin
      rd(chAddr(c, `TPC_CH_VH), hi);
      rd(chAddr(c, `TPC_CH_VL), lo);
      chk({hi, lo}, 0);
    end
    chk(overflowIrq, 0);
    chk(chPin[0].oeN, 1);
    // Compare values with clock off, both byte orders, extremes first
    for (int i = 0; i < 6; i++) begin
      ch = i % 2;
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom_range(65535));
      wr(chAddr(ch, `TPC_CH_SC), 8'h14);
      if (i[1]) begin
        wr(chAddr(ch, `TPC_CH_VL), v[7:0]);
        wr(chAddr(ch, `TPC_CH_VH), v[15:8]);
      end else begin
        wr(chAddr(ch, `TPC_CH_VH), v[15:8]);
        wr(chAddr(ch, `TPC_CH_VL), v[7:0]);
      end
      rd(chAddr(ch, `TPC_CH_VH), hi);
      rd(chAddr(ch, `TPC_CH_VL), lo);
      chk({hi, lo}, v);
      chk(chPin[ch].oeN, 0);
    end
    // Capture mode drops value writes
    wr(chAddr(1, `TPC_CH_SC), 8'h04);
    wr(chAddr(1, `TPC_CH_VH), ~v[15:8]);
    wr(chAddr(1, `TPC_CH_VL), ~v[7:0]);
    rd(chAddr(1, `TPC_CH_VH), hi);
    rd(chAddr(1, `TPC_CH_VL), lo);
    chk({hi, lo}, v);
    // Halted value writes land directly in the channel register
    debugHalt <= 1'b1;
    wr(chAddr(0, `TPC_CH_SC), 8'h14);
    wr(chAddr(0, `TPC_CH_VH), 8'h5a);
    rd(chAddr(0, `TPC_CH_VH), hi);
    chk(hi, 8'h5a);
    debugHalt <= 1'b0;
    wr(chAddr(0, `TPC_CH_SC), 8'h10);
    rd(`TPC_OFF_CTRL, r);
    chk(chPin[0].oeN, 1);
    // Modulo first, so the counter never runs past it before the wrap test
    m = $urandom_range(3, 9);
    wr(`TPC_OFF_MODL, 8'(m));
    wr(`TPC_OFF_MODH, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(`TPC_OFF_CTRL, 8'(c << 3));
      rd(`TPC_OFF_CTRL, r);
      chk(r & 8'h18, 16'(c << 3));
    end
    // Up counting with a small modulo
    wr(`TPC_OFF_CTRL, 8'h48);
    repeat (3 * (m + 1)) @(posedge core_clk);
    wr(`TPC_OFF_CTRL, 8'hc0);
    rd(`TPC_OFF_CTRL, r);
    chk(r, 8'hc0);
    chk(overflowIrq, 1);
    rd(`TPC_OFF_CNTL, lo);
    rd(`TPC_OFF_CNTH, hi);
    chk(hi, 0);
    chk(lo <= m, 1);
    rd(`TPC_OFF_CNTL, r);
    chk(r, lo);
    wr(`TPC_OFF_CTRL, 8'h40);
    rd(`TPC_OFF_CTRL, r);
    chk(overflowIrq, 0);
    wr(`TPC_OFF_CTRL, 8'h08);
    repeat (3 * (m + 1)) @(posedge core_clk);
    wr(`TPC_OFF_CTRL, 8'h80);
    rd(`TPC_OFF_CTRL, r);
    chk(r, 8'h80);
    chk(overflowIrq, 0);
    // Halt freezes the running counter
    wr(`TPC_OFF_CTRL, 8'h08);
    debugHalt <= 1'b1;
    rd(`TPC_OFF_CNTL, lo);
    rd(`TPC_OFF_CNTL, r);
    chk(r, lo);
    debugHalt <= 1'b0;
    // Capture edge selection, codes 01, 10 and 11 against both edges
    for (int c = 1; c < 4; c++) begin
      e = 2'(c);
      wr(chAddr(0, `TPC_CH_SC), {4'h0, e, 2'h0});
      chIn[0] <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(chAddr(0, `TPC_CH_SC), r);
      chk(r[7], e[0]);
      wr(chAddr(0, `TPC_CH_SC), {4'h0, e, 2'h0});
      chIn[0] <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd(chAddr(0, `TPC_CH_SC), r);
      chk(r[7], e[1]);
      rd(chAddr(0, `TPC_CH_VH), hi);
      rd(chAddr(0, `TPC_CH_VL), lo);
      chk({hi, lo} <= m, 1);
    end
    // PWM duty in edge and center modes, both polarities
    m = 9;
    v = 16'($urandom_range(1, 8));
    wr(`TPC_OFF_CTRL, 8'h00);
    wr(`TPC_OFF_MODL, 8'(m));
    wr(chAddr(1, `TPC_CH_SC), 8'h28);
    wr(chAddr(1, `TPC_CH_VH), v[15:8]);
    wr(chAddr(1, `TPC_CH_VL), v[7:0]);
    for (int k = 0; k < 4; k++) begin
      wr(`TPC_OFF_CTRL, 8'h00);
      wr(chAddr(1, `TPC_CH_SC), k[0] ? 8'h24 : 8'h28);
      wr(`TPC_OFF_CTRL, k[1] ? 8'h28 : 8'h08);
      repeat (4 * m + 4) @(posedge core_clk);
      cntHigh(1, k[1] ? 2 * m : m + 1, h);
      if (k[1]) begin
        chk(16'(h), 16'(pwmHigh(v, m, 1'b1, k[0])));
      end else begin
        chk(16'(h), 16'(pwmHigh(v, m, 1'b0, k[0])));
      end
    end
    wr(`TPC_OFF_CTRL, 8'ha0);
    rd(`TPC_OFF_CTRL, r);
    chk(r[7], 1);
    stop_test();
  end
endmodule
